//--- core/burst2_sram_cmd_dll_init.sv
// burst-of-two ddr sram core: commands, data beats, dll lock sequencing
`timescale 1ns/10ps
// Summary of operation
// - option2 keeps dq termination rules but input clock termination off
// - after stable clocks, wait the lock period before accepting commands
// - with the delay loop disabled, skip locking but still wait
// - input clock static over 30 ns resets the loop; relock follows
// - rising edge on the delay-loop enable resets the loop
// - second beat address is first address plus one, internally
// - read: first beat at t+2.5, second beat at t+3.0
// - write: lane enables sampled at t+1.0 and t+1.5
// - new address taken only when load strobe is low
// - clocks stop only when idle; data pins hold previous state
// - x18: two enables gate 9-bit lanes; both high abort the beat
// - x36: four enables gate 9-bit lanes; all high abort the beat
// - lock period is 2048 stable input clock cycles
// - dq termination off half cycle before read data, on after
// - delay loop disabled gives one-cycle read latency
module burst2_sram_cmd_dll_init (
  // system clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // input clock pair (k_clk is the link clock)
  input  wire logic                        k_clk,
  input  wire logic                        k_n,
  // command pins, k_clk domain
  input  wire logic                        load_strobe_n,
  input  wire logic                        read_sel,
  input  wire logic [sram_pkg::ADDR_W-1:0] addr,
  input  wire logic                        byte_enable_lane0_n,
  input  wire logic                        byte_enable_lane1_n,
  input  wire logic                        byte_enable_lane2_n,
  input  wire logic                        byte_enable_lane3_n,
  // common data pins
  input  wire logic [sram_pkg::DQ_W-1:0]   dq_in,
  output logic      [sram_pkg::DQ_W-1:0]   dq_out,
  output logic                             dq_oe,
  // straps
  input  wire logic                        dll_enable,
  input  wire logic                        odt_option2,
  input  wire logic                        narrow_x18,
  // termination and status
  output logic                             odt_dq_en,
  output logic                             odt_clk_en_q,
  output logic                             device_ready_q,
  output logic                             dll_locked_q
);

  // ------------------------------------------------------------------
  // system domain: clock watch and lock sequencing
  // ------------------------------------------------------------------
  logic                        k_s;
  logic                        kn_s;
  logic                        dll_s;
  logic                        opt2_s;
  logic                        k_prev_q;
  logic                        kn_prev_q;
  logic                        dll_prev_q;
  logic [sram_pkg::STOP_W-1:0] stall_q;
  logic [sram_pkg::STOP_W-1:0] stall_d;
  logic [sram_pkg::LOCK_W-1:0] lock_cnt_q;
  logic [sram_pkg::LOCK_W-1:0] lock_cnt_d;
  sram_pkg::dll_state_t        state_q;
  sram_pkg::dll_state_t        state_d;
  logic                        k_rise;
  logic                        k_moved;
  logic                        stop_evt;
  logic                        dll_rise;
  logic                        dll_rst;
  logic                        lock_done;

  level_sync #(.W(4)) u_sys_sync (
    .clk (sys_clk),
    .d   ({k_clk, k_n, dll_enable, odt_option2}),
    .q   ({k_s, kn_s, dll_s, opt2_s})
  );

  // event decode; either clock pin held static lets the stall count run
  assign k_rise    = k_s & ~k_prev_q;
  assign k_moved   = (k_s != k_prev_q) & (kn_s != kn_prev_q);
  assign stop_evt  = (stall_q == sram_pkg::STOP_W'(sram_pkg::STOP_CYC));
  assign dll_rise  = dll_s & ~dll_prev_q;
  assign dll_rst   = stop_evt | dll_rise;
  assign lock_done = k_rise &
    (lock_cnt_q == sram_pkg::LOCK_W'(sram_pkg::LOCK_CYCLES - 1));

  // clock-static counter saturates, holding the loop in reset
  assign stall_d = k_moved  ? '0 :
                   stop_evt ? stall_q :
                   stall_q + sram_pkg::STOP_W'(1);

  // lock counter runs in both loop modes; only rises of k count
  assign lock_cnt_d = (dll_rst | (state_q == sram_pkg::ST_RUN)) ? '0 :
                      k_rise ? lock_cnt_q + sram_pkg::LOCK_W'(1) :
                      lock_cnt_q;

  // lock sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sram_pkg::ST_LOCK: begin
        if (!dll_rst && lock_done) begin
          state_d = sram_pkg::ST_RUN;
        end
      end
      sram_pkg::ST_RUN: begin
        if (dll_rst) begin
          state_d = sram_pkg::ST_LOCK;
        end
      end
      default: state_d = sram_pkg::ST_LOCK;
    endcase
  end

  // system domain registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q        <= sram_pkg::ST_LOCK;
      lock_cnt_q     <= '0;
      stall_q        <= '0;
      k_prev_q       <= k_s;              // no false edge after reset
      kn_prev_q      <= kn_s;
      dll_prev_q     <= dll_s;
      device_ready_q <= 1'b0;
      dll_locked_q   <= 1'b0;
      odt_clk_en_q   <= 1'b0;
    end else begin
      state_q        <= state_d;
      lock_cnt_q     <= lock_cnt_d;
      stall_q        <= stall_d;
      k_prev_q       <= k_s;
      kn_prev_q      <= kn_s;
      dll_prev_q     <= dll_s;
      device_ready_q <= (state_d == sram_pkg::ST_RUN);
      dll_locked_q   <= (state_d == sram_pkg::ST_RUN) & dll_s;
      odt_clk_en_q   <= ~opt2_s;
    end
  end

  // ------------------------------------------------------------------
  // link domain: commands, beats, array
  // ------------------------------------------------------------------
  logic                        ready_k;
  logic                        dll_k;
  logic                        x18_k;
  logic [sram_pkg::LANES-1:0]  be_n;
  logic [sram_pkg::LANES-1:0]  be0_q;
  logic [sram_pkg::PIPE_D-1:0] rd_s_q;
  logic [sram_pkg::ADDR_W-1:0] a0_q;
  logic [sram_pkg::ADDR_W-1:0] a1_q;
  logic [sram_pkg::ADDR_W-1:0] a2_q;
  logic                        wr1_q;
  logic                        wr2_q;
  logic [sram_pkg::DQ_W-1:0]   wd0_q;
  logic [sram_pkg::DQ_W-1:0]   dq_p_q;
  logic [sram_pkg::DQ_W-1:0]   dq_n_q;
  logic                        oe_p_q;
  logic                        oe_n_q;
  logic                        odt_off_p_q;
  logic                        odt_off_n_q;
  logic                        cmd_ok;
  logic                        rd_go;
  logic                        wr_go;
  logic [sram_pkg::DQ_W-1:0]   mask0;
  logic [sram_pkg::DQ_W-1:0]   mask1;
  logic                        abort0;
  logic                        abort1;
  logic [sram_pkg::DQ_W-1:0]   wdat0;
  logic [sram_pkg::DQ_W-1:0]   wdat1;
  logic                        rd_p_act;
  logic                        rd_n_act;
  logic [sram_pkg::ADDR_W-1:0] rd_p_addr;
  logic [sram_pkg::ADDR_W-1:0] rd_n_addr;
  logic                        rd_p_beat;
  logic                        rd_n_beat;
  logic [sram_pkg::ADDR_W-1:0] w_idx0;
  logic [sram_pkg::ADDR_W-1:0] w_idx1;
  logic [sram_pkg::DQ_W-1:0]   mem [sram_pkg::MEM_WORDS];

  level_sync #(.W(3)) u_link_sync (
    .clk (k_clk),
    .d   ({device_ready_q, dll_enable, narrow_x18}),
    .q   ({ready_k, dll_k, x18_k})
  );

  // word index: x36 appends the beat bit, x18 keeps the address and ignores the beat
  function automatic logic [sram_pkg::ADDR_W-1:0] word_idx(
    input logic [sram_pkg::ADDR_W-1:0] a,
    input logic                        beat,
    input logic                        narrow
  );
    return narrow ? a : {a[sram_pkg::ADDR_W-2:0], beat};
  endfunction : word_idx

  // read data placed on the pins for the selected width
  function automatic logic [sram_pkg::DQ_W-1:0] rd_word(
    input logic [sram_pkg::DQ_W-1:0] w,
    input logic                      beat,
    input logic                      narrow
  );
    if (!narrow) begin
      return w;
    end
    return {{sram_pkg::HALF_W{1'b0}},
            beat ? w[sram_pkg::DQ_W-1:sram_pkg::HALF_W]
                 : w[sram_pkg::HALF_W-1:0]};
  endfunction : rd_word

  // command decode; load high is a no-operation
  assign cmd_ok = ready_k & ~load_strobe_n;
  assign rd_go  = cmd_ok & read_sel;
  assign wr_go  = cmd_ok & ~read_sel;
  assign be_n   = {byte_enable_lane3_n, byte_enable_lane2_n,
                   byte_enable_lane1_n, byte_enable_lane0_n};

  // lane masks for both beats
  lane_mask #(.HALF(1'b0)) u_mask0 (
    .be_n   (be0_q),
    .narrow (x18_k),
    .mask   (mask0),
    .abort  (abort0)
  );
  lane_mask #(.HALF(1'b1)) u_mask1 (
    .be_n   (be_n),
    .narrow (x18_k),
    .mask   (mask1),
    .abort  (abort1)
  );

  // write data and addresses; x18 repeats the half on both sides
  assign wdat0  = x18_k ? {2{wd0_q[sram_pkg::HALF_W-1:0]}} : wd0_q;
  assign wdat1  = x18_k ? {2{dq_in[sram_pkg::HALF_W-1:0]}} : dq_in;
  assign w_idx0 = word_idx(a1_q, 1'b0, x18_k);
  assign w_idx1 = word_idx(a1_q, 1'b1, x18_k);

  // read beat selection; loop off moves data to t+1.0 and t+1.5
  assign rd_n_act  = dll_k ? rd_s_q[2] : rd_s_q[1];
  assign rd_n_addr = dll_k ? a2_q : a1_q;
  assign rd_n_beat = ~dll_k;
  assign rd_p_act  = dll_k ? rd_s_q[2] : rd_s_q[0];
  assign rd_p_addr = dll_k ? a2_q : a0_q;
  assign rd_p_beat = dll_k;

  // k rise: command pipe, first write beat, k-timed read beat
  always_ff @(posedge k_clk) begin
    if (!ready_k) begin
      rd_s_q      <= '0;
      wr1_q       <= 1'b0;
      wr2_q       <= 1'b0;
      oe_p_q      <= 1'b0;
      odt_off_p_q <= 1'b0;
    end else begin
      rd_s_q      <= {rd_s_q[sram_pkg::PIPE_D-2:0], rd_go};
      wr1_q       <= wr_go;
      wr2_q       <= wr1_q;
      oe_p_q      <= rd_p_act;
      odt_off_p_q <= rd_s_q[1] | rd_s_q[2];
    end
  end

  // address pipe and first-beat write capture
  always_ff @(posedge k_clk) begin
    a0_q <= cmd_ok ? addr : a0_q;
    a1_q <= a0_q;
    a2_q <= a1_q;
    if (wr1_q) begin
      wd0_q <= dq_in;
      be0_q <= be_n;
    end
    if (rd_p_act) begin
      dq_p_q <= rd_word(mem[word_idx(rd_p_addr, rd_p_beat, x18_k)],
                        rd_p_beat, x18_k);
    end
  end

  // k# rise (k fall): second write beat, array update, k#-timed read
  always_ff @(negedge k_clk) begin
    if (!ready_k) begin
      oe_n_q      <= 1'b0;
      odt_off_n_q <= 1'b0;
    end else begin
      oe_n_q      <= rd_n_act;
      odt_off_n_q <= rd_s_q[0] | rd_s_q[1];
    end
    if (rd_n_act) begin
      dq_n_q <= rd_word(mem[word_idx(rd_n_addr, rd_n_beat, x18_k)],
                        rd_n_beat, x18_k);
    end
    if (ready_k && wr2_q) begin
      if (x18_k) begin
        mem[w_idx0] <= (mem[w_idx0] & ~(mask0 | mask1)) |
                       (wdat0 & mask0) | (wdat1 & mask1);
      end else begin
        mem[w_idx0] <= (mem[w_idx0] & ~mask0) | (wdat0 & mask0);
        mem[w_idx1] <= (mem[w_idx1] & ~mask1) | (wdat1 & mask1);
      end
    end
  end

  // pin view: each half of the k period shows its own beat register;
  // with k stopped, the registers simply hold their last state
  assign dq_out    = k_clk ? dq_p_q : dq_n_q;
  assign dq_oe     = k_clk ? oe_p_q : oe_n_q;
  assign odt_dq_en = ~(dll_k ? odt_off_p_q : odt_off_n_q);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_read_cmd;
    rd_go && dll_k;
  endsequence

  sequence s_both_beats;
    ##3 oe_n_q ##1 oe_p_q;
  endsequence

  a_read_beats: assert property (
    @(posedge k_clk) disable iff (!ready_k)
    s_read_cmd |-> s_both_beats)
    else $error("read beats not driven at t+2.5 and t+3.0");

  a_fast_read: assert property (
    @(posedge k_clk) disable iff (!ready_k)
    (rd_go && !dll_k && $stable(dll_k)) |-> ##2 (oe_p_q && oe_n_q))
    else $error("loop-off read not driven at one cycle");

  a_nop_quiet: assert property (
    @(posedge k_clk) disable iff (!ready_k)
    (load_strobe_n && rd_s_q == '0) |=> !oe_p_q)
    else $error("data driven with no read in flight");

  a_odt_read: assert property (
    @(posedge k_clk) disable iff (!ready_k)
    s_read_cmd |-> ##3 odt_off_p_q [*2] ##1 (!odt_off_p_q || rd_s_q[2]))
    else $error("dq termination window wrong");

  a_abort_lanes: assert property (
    @(posedge k_clk) disable iff (!ready_k)
    (!x18_k && &be_n) |-> (abort1 && mask1 == '0))
    else $error("all-high enables did not abort the beat");

  a_narrow_lanes: assert property (
    @(posedge k_clk) disable iff (!ready_k)
    (x18_k && !be_n[0] && be_n[1]) |->
      mask1 == {{sram_pkg::LANE_W{1'b0}}, {sram_pkg::LANE_W{1'b1}},
                {sram_pkg::HALF_W{1'b0}}})
    else $error("x18 lane 0 mask wrong");

  a_stop_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    stop_evt |=> !device_ready_q ##1 !device_ready_q)
    else $error("static clock did not reset the loop");

  a_toggle_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    dll_rise |=> (!device_ready_q && lock_cnt_q == '0))
    else $error("enable rise did not restart locking");

  a_lock_wait: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(device_ready_q) |->
      $past(lock_cnt_q) == sram_pkg::LOCK_W'(sram_pkg::LOCK_CYCLES - 1))
    else $error("ready before the lock period");

  a_skip_lock: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !$past(dll_s) |-> !dll_locked_q)
    else $error("locked reported with the loop disabled");

  a_clk_odt: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> (odt_clk_en_q == !$past(opt2_s)))
    else $error("clock termination does not follow option");

endmodule : burst2_sram_cmd_dll_init

//--- core/lane_mask.sv
// per-beat write mask from the active-low lane enables
`timescale 1ns/10ps
module lane_mask #(
  parameter bit HALF = 1'b0
) (
  // lane enables and width mode
  input  wire logic [sram_pkg::LANES-1:0] be_n,
  input  wire logic                       narrow,
  // bit mask into the stored word, and the all-disabled flag
  output logic      [sram_pkg::DQ_W-1:0]  mask,
  output logic                            abort
);

  logic [sram_pkg::LANES-1:0] lane_on;

  // narrow mode uses lanes 0/1, placed in the half picked by the beat
  generate
    for (genvar i = 0; i < sram_pkg::LANES; i++) begin : g_lane
      localparam int SRC = i % sram_pkg::HALF_LN;
      localparam bit HI  = (i >= sram_pkg::HALF_LN);
      assign lane_on[i] = narrow ? (~be_n[SRC] & (HI == HALF))
                                 : ~be_n[i];
      assign mask[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
        {sram_pkg::LANE_W{lane_on[i]}};
    end
  endgenerate

  // all enables high abort the beat
  assign abort = ~|lane_on;

endmodule : lane_mask

//--- core/level_sync.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/10ps
module level_sync #(
  parameter int W = 1
) (
  // destination clock
  input  wire logic         clk,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule : level_sync

//--- inc/sram_pkg.sv
// constants and state codes shared by the burst-of-two sram core
package sram_pkg;

  // system clock and clock-stop detection
  localparam int CLK_NS     = 25;
  localparam int STOP_NS    = 30;
  localparam int STOP_CYC   = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STOP_W     = 3;

  // delay loop lock period, counted in input clock rises
  localparam int LOCK_CYCLES = 2048;
  localparam int LOCK_W      = 12;

  // array and pin geometry
  localparam int ADDR_W    = 20;
  localparam int DQ_W      = 36;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int HALF_W    = 18;
  localparam int HALF_LN   = 2;
  localparam int MEM_WORDS = 1 << ADDR_W;

  // pipeline depth of the read/command shift register
  localparam int PIPE_D = 3;

  // delay loop sequencer states
  typedef enum logic [1:0] {
    ST_LOCK = 2'h1,
    ST_RUN  = 2'h2
  } dll_state_t;

endpackage : sram_pkg

//--- sim/host_model.sv
// host controller model: input clock pair, command pins, write data
`timescale 1ns/10ps
module host_model (
  // input clock pair
  output logic                        k_clk,
  output logic                        k_n,
  // command pins
  output logic                        load_strobe_n,
  output logic                        read_sel,
  output logic [sram_pkg::ADDR_W-1:0] addr,
  output logic [sram_pkg::LANES-1:0]  be_n,
  // write data
  output logic [sram_pkg::DQ_W-1:0]   dq_in
);
  logic k_run;

  // every pin at a defined level from time zero
  initial begin
    k_run = 1'b1;
    load_strobe_n = 1'b1;
    read_sel = 1'b1;
    addr = 20'h0_0000;
    be_n = 4'hf;
    dq_in = 36'h0_0000_0000;
  end

  // free-running 64 ns clock, halted only on request; the period never
  // changes, so no frequency change calls for a loop reset
  initial begin
    k_clk = 1'b0;
    #7;
    forever #32 if (k_run) k_clk = ~k_clk;
  end
  assign k_n = ~k_clk;

  // one command or nop at the next rise, released after it
  task automatic issue(input logic ld, input logic rd,
                       input logic [19:0] a);
    @(posedge k_clk);
    load_strobe_n <= ld;
    read_sel      <= rd;
    addr          <= a;
    @(posedge k_clk);
    load_strobe_n <= 1'b1;
    read_sel      <= ~rd;
    addr          <= ~a;
  endtask : issue

  // late write: beat 0 for rise t+1, beat 1 for fall t+1.5
  task automatic write(input logic [19:0] a, input logic [35:0] d0,
                       input logic [35:0] d1, input logic [3:0] b0,
                       input logic [3:0] b1);
    issue(1'b0, 1'b0, a);
    dq_in <= d0;
    be_n  <= b0;
    @(posedge k_clk);
    dq_in <= d1;
    be_n  <= b1;
    @(negedge k_clk);
    dq_in <= ~d1;
    be_n  <= ~b1;
  endtask : write

  // stop both clock pins at a static level, bursts already done
  task automatic hold_clocks(input bit h);
    k_run = ~h;
  endtask : hold_clocks
endmodule : host_model

//--- sim/testbench.sv
// self-checking bench for the burst-of-two sram core
`timescale 1ns/10ps
module testbench;
  localparam logic [19:0] A = 20'h0_0123;
  logic        sys_clk;
  logic        rst_n;
  logic        dll_enable;
  logic        odt_option2;
  logic        narrow_x18;
  logic        k_clk;
  logic        k_n;
  logic        load_strobe_n;
  logic        read_sel;
  logic [19:0] addr;
  logic [3:0]  be_n;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic        dq_oe;
  logic        odt_dq_en;
  logic        odt_clk_en_q;
  logic        device_ready_q;
  logic        dll_locked_q;
  logic [35:0] w0;
  logic [35:0] w1;
  int          mismatches;
  int          comparisons;

  host_model i_host (.k_clk(k_clk), .k_n(k_n), .load_strobe_n(load_strobe_n),
    .read_sel(read_sel), .addr(addr), .be_n(be_n), .dq_in(dq_in));

  burst2_sram_cmd_dll_init i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .k_clk(k_clk), .k_n(k_n), .load_strobe_n(load_strobe_n),
    .read_sel(read_sel), .addr(addr), .byte_enable_lane0_n(be_n[0]),
    .byte_enable_lane1_n(be_n[1]), .byte_enable_lane2_n(be_n[2]),
    .byte_enable_lane3_n(be_n[3]), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .dll_enable(dll_enable), .odt_option2(odt_option2),
    .narrow_x18(narrow_x18), .odt_dq_en(odt_dq_en),
    .odt_clk_en_q(odt_clk_en_q), .device_ready_q(device_ready_q),
    .dll_locked_q(dll_locked_q));

  // 40 MHz system clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // compare and count
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // expected word after a lane-gated write
  function automatic logic [35:0] merge(input logic [35:0] old,
                                        input logic [35:0] nw,
                                        input logic [3:0] b);
    merge = old;
    for (int l = 0; l < 4; l++)
      if (!b[l]) merge[l*9 +: 9] = nw[l*9 +: 9];
  endfunction : merge

  // ready must stay low past 2000 rises and rise shortly after 2048
  task automatic wait_lock();
    int n;
    n = 0;
    repeat (2000) @(posedge k_clk);
    chk(36'(device_ready_q), 36'h0_0000_0000);
    while (device_ready_q !== 1'b1 && n < 100) begin
      @(posedge k_clk);
      n++;
    end
    chk(36'(device_ready_q), 36'h0_0000_0001);
    repeat (3) @(posedge k_clk);
  endtask : wait_lock

  // read burst and judge beats, drive enable and termination
  task automatic rd_chk(input logic [19:0] a, input logic [35:0] e0,
                        input logic [35:0] e1, input bit fast);
    i_host.issue(1'b0, 1'b1, a);
    if (fast)
      @(posedge k_clk);
    else
      repeat (3) @(negedge k_clk);
    #16;
    chk(dq_out, e0);
    chk(36'(dq_oe), 36'h0_0000_0001);
    chk(36'(odt_dq_en), 36'h0_0000_0000);
    if (fast)
      @(negedge k_clk);
    else
      @(posedge k_clk);
    #16;
    chk(dq_out, e1);
    @(posedge k_clk);
    #16;
    chk(36'(dq_oe), 36'h0_0000_0000);
    if (!fast)
      chk(36'(odt_dq_en), 36'h0_0000_0001);
  endtask : rd_chk

  // loop held off from power-up: wait still applies, no lock
  task automatic t_power_up();
    wait_lock();
    chk(36'(dll_locked_q), 36'h0_0000_0000);
    chk(36'(odt_clk_en_q), 36'h0_0000_0001);
    w0 = 36'h1_2345_6789;
    w1 = 36'ha_bcde_f012;
    i_host.write(A, w0, w1, 4'h0, 4'h0);
    rd_chk(A, w0, w1, 1'b1);
  endtask : t_power_up

  // enable raised on stable clock resets and relocks the loop
  task automatic t_loop_reset();
    @(posedge sys_clk);
    dll_enable <= 1'b1;
    wait_lock();
    chk(36'(dll_locked_q), 36'h0_0000_0001);
  endtask : t_loop_reset

  // each single lane per beat, then an aborted beat 0
  task automatic t_lanes();
    logic [35:0] d0;
    logic [3:0]  b0;
    logic [3:0]  b1;
    for (int l = 0; l < 5; l++) begin
      d0 = 36'h9_8765_4321 ^ 36'(l * 291);
      b0 = (l < 4) ? ~(4'h1 << l) : 4'hf;
      b1 = (l < 4) ? ~(4'h8 >> l) : 4'h0;
      i_host.write(A, d0, ~d0, b0, b1);
      w0 = merge(w0, d0, b0);
      w1 = merge(w1, ~d0, b1);
      rd_chk(A, w0, w1, 1'b0);
    end
  endtask : t_lanes

  // load high: no read even with read select high
  task automatic t_nop();
    i_host.issue(1'b1, 1'b1, A);
    repeat (8) begin
      @(k_clk);
      #16;
      chk(36'(dq_oe), 36'h0_0000_0000);
      chk(36'(odt_dq_en), 36'h0_0000_0001);
    end
  endtask : t_nop

  // clocks stopped 200 ns: pins hold, loop resets and relocks
  task automatic t_clock_stop();
    logic [35:0] q;
    @(negedge k_clk);
    #1;
    q = dq_out;
    i_host.hold_clocks(1'b1);
    #200;
    chk(dq_out, q);
    chk(36'(dq_oe), 36'h0_0000_0000);
    chk(36'(device_ready_q), 36'h0_0000_0000);
    i_host.hold_clocks(1'b0);
    wait_lock();
  endtask : t_clock_stop

  // 18-bit width with option2 termination
  task automatic t_narrow();
    logic [35:0] d0;
    logic [35:0] d1;
    d0 = 36'h0_0001_5a5a;
    d1 = 36'h0_0002_c3c3;
    @(posedge sys_clk);
    narrow_x18 <= 1'b1;
    odt_option2 <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(36'(odt_clk_en_q), 36'h0_0000_0000);
    i_host.write({A[18:0], 1'b0}, d0, d1, 4'he, 4'hd);
    rd_chk({A[18:0], 1'b0}, {18'h0_0000, w0[17:9], d0[8:0]},
           {18'h0_0000, d1[17:9], w0[26:18]}, 1'b0);
  endtask : t_narrow

  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    mismatches = 0;
    comparisons = 0;
    rst_n = 1'b0;
    dll_enable = 1'b0;
    odt_option2 = 1'b0;
    narrow_x18 = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_power_up();
    t_loop_reset();
    t_lanes();
    t_nop();
    t_clock_stop();
    t_narrow();
    end_of_test();
  end

  // three lock periods take about 0.4 ms; give up at 1 ms
  initial begin
    #1_000_000;
    mismatches++;
    end_of_test();
  end
endmodule : testbench
